// ---- hw/ata_host_port.sv ----
// Device end of the parallel host port: PIO wait, multiword and Ultra DMA.
//
// Contract
// - Drive ready/wait low to lengthen PIO.
// - Ready held high means no wait.
// - Early low wait holds cycle until release.
// - Read data valid before ready reasserts.
// - Device reports minimum DMA cycle time.
// - Device accepts any legal host timing.
// - Device drops DMA request to suspend.
// - Ultra DMA pin meanings only in bursts.
// - Read burst: HDMARDY, DSTROBE, STOP mapping.
// - Write burst: HSTROBE, DDMARDY, STOP mapping.
// - Both strobe edges carry one word.
// - Disk mode decodes three address lines.
// - Sender stops strobing after ready negated.
// - Recipient waits ready-to-pause before pausing.
// - Sender waits after last strobe to end.
`timescale 1ns/1ps
module ata_host_port
	import ata_port_pkg::*;
(
	input wire logic ref_clk, // Core clock, 125 MHz.
	input wire logic rst, // Synchronous reset, active high.
	input wire logic host_read_strobe_n, // Read strobe / HDMARDY# / HSTROBE.
	input wire logic host_write_strobe_n, // Write strobe / STOP.
	input wire logic attribute_select_n, // Attribute select / DMACK#.
	input wire logic card_enable_low_n, // Low card enable.
	input wire logic card_enable_high_n, // High card enable.
	input wire logic [10:0] host_address_bus, // Host address lines.
	input wire logic [15:0] host_data_bus_in, // Data bus as seen on pins.
	output logic [15:0] host_data_bus_out, // Data driven to host.
	output logic host_data_bus_oe, // High while driving the data bus.
	output logic ready_wait_out, // Ready-wait / DSTROBE / DDMARDY#.
	output logic dma_request_out, // DMA request, active high.
	input wire xfer_cfg_t cfg, // Transfer configuration.
	output pio_req_t pio_req, // Register cycle request.
	output logic pio_req_valid, // One-cycle pulse with pio_req.
	input wire logic [15:0] pio_rd_data, // Read answer data.
	input wire logic pio_done, // Controller answered the cycle.
	input wire logic [15:0] dma_rd_word, // Next word toward the host.
	input wire logic dma_rd_valid, // dma_rd_word is available.
	output logic dma_rd_take, // One-cycle pulse: word consumed.
	output logic [15:0] dma_wr_word, // Word received from the host.
	output logic dma_wr_valid, // One-cycle pulse with dma_wr_word.
	input wire logic dma_wr_ready, // Controller can take more words.
	output logic [15:0] crc_word, // CRC word closing a burst.
	output logic crc_valid, // One-cycle pulse with crc_word.
	output logic burst_active // High inside an Ultra DMA burst.
);

	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_PIO_WAIT = 3'b001,
		S_PIO_DATA = 3'b010,
		S_PIO_HOLD = 3'b011,
		S_UD_RD = 3'b100,
		S_UD_WR = 3'b101,
		S_UD_END = 3'b110
	} state_t;

	state_t state_q;
	host_pins_t pin;
	host_pins_t pin_prev_q;
	logic [PINS_W-1:0] pins_sync;
	logic pio_write_q;
	logic [10:0] pio_addr_q;
	logic [7:0] tmr_q;
	logic phase_q;
	logic paused_q;

	// Every pin, data included, shares the same two-stage delay so that
	// strobe edges and the data they qualify stay aligned.
	pin_sync #(
		.W(PINS_W),
		.INIT({5'h1F, 11'h000, 16'h0000})
	) u_sync (
		.ref_clk(ref_clk),
		.rst(rst),
		.d({host_read_strobe_n, host_write_strobe_n, attribute_select_n,
			card_enable_low_n, card_enable_high_n, host_address_bus,
			host_data_bus_in}),
		.q(pins_sync)
	);

	assign pin = host_pins_t'(pins_sync);

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pin_prev_q <= host_pins_t'({5'h1F, 11'h000, 16'h0000});
		end else begin
			pin_prev_q <= pin;
		end
	end

	wire rd_fall = pin_prev_q.rd_n & ~pin.rd_n;
	wire rd_rise = ~pin_prev_q.rd_n & pin.rd_n;
	wire wr_fall = pin_prev_q.wr_n & ~pin.wr_n;
	wire wr_rise = ~pin_prev_q.wr_n & pin.wr_n;
	wire hstrobe_edge = pin_prev_q.rd_n ^ pin.rd_n;
	wire card_sel = ~pin.ce_low_n | ~pin.ce_high_n;
	wire dmack = ~pin.dmack_n;
	wire dmack_end = ~pin_prev_q.dmack_n & pin.dmack_n;
	wire hdmardy = ~pin.rd_n;
	wire stop_req = ~pin.wr_n;
	wire udma_start = dmack & cfg.udma_en & cfg.dma_active;
	wire mdma_cycle = dmack & ~cfg.udma_en;
	wire pio_start = ~dmack & card_sel & (rd_fall | wr_fall);
	wire tmr_zero = (tmr_q == TMR_RST);
	wire [7:0] tmr_dec = tmr_q - 8'h01;

	// Only the three low address lines count in the disk mode.
	wire [10:0] dec_addr = cfg.disk_mode ?
		{8'h00, pin.addr[DISK_ADDR_BITS-1:0]} : pin.addr;

	// Limits come from the configured mode only, which is the mode the
	// controller advertised as this device's fastest cycle.
	wire [7:0] half_cyc = udma_half_cyc(cfg.mode);
	wire [7:0] rp_cyc = udma_rp_cyc(cfg.mode);

	// The request follows what the controller can sustain right now, so a
	// slow controller suspends and resumes the host by itself.
	wire dmarq_idle = cfg.dma_active &
		(cfg.dma_read ? dma_rd_valid : dma_wr_ready);

	// Read burst may end when nothing is pending or the host asks to stop.
	wire rd_burst_end = phase_q == 1'b0 & (stop_req | ~dma_rd_valid);

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_q <= S_IDLE;
			ready_wait_out <= READY_RST;
			dma_request_out <= DMARQ_RST;
			host_data_bus_oe <= OE_RST;
			host_data_bus_out <= DATA_RST;
			pio_req <= '0;
			pio_req_valid <= 1'b0;
			pio_write_q <= 1'b0;
			pio_addr_q <= 11'h000;
			dma_rd_take <= 1'b0;
			dma_wr_word <= DATA_RST;
			dma_wr_valid <= 1'b0;
			crc_word <= DATA_RST;
			crc_valid <= 1'b0;
			burst_active <= 1'b0;
			tmr_q <= TMR_RST;
			phase_q <= 1'b0;
			paused_q <= 1'b0;
		end else begin
			pio_req_valid <= 1'b0;
			dma_rd_take <= 1'b0;
			dma_wr_valid <= 1'b0;
			crc_valid <= 1'b0;
			unique case (state_q)
			S_IDLE: begin
				// Outside a burst the pins keep their plain meanings.
				ready_wait_out <= READY_RST;
				burst_active <= 1'b0;
				dma_request_out <= dmarq_idle;
				if (udma_start) begin
					burst_active <= 1'b1;
					phase_q <= 1'b0;
					// A write burst that opens not ready counts as paused, or
					// nothing would ever assert the ready again.
					paused_q <= ~cfg.dma_read & ~dma_wr_ready;
					tmr_q <= TMR_RST;
					// Write burst starts with DDMARDY# per readiness.
					ready_wait_out <= cfg.dma_read ? 1'b1 : ~dma_wr_ready;
					state_q <= cfg.dma_read ? S_UD_RD : S_UD_WR;
				end else if (mdma_cycle) begin
					// Edge driven, so any longer active or recovery phase
					// from the host is accepted.
					if (rd_fall & cfg.dma_read) begin
						host_data_bus_out <= dma_rd_word;
						host_data_bus_oe <= 1'b1;
						dma_rd_take <= 1'b1;
					end
					if (rd_rise) begin
						host_data_bus_oe <= 1'b0;
					end
					if (wr_rise & ~cfg.dma_read) begin
						dma_wr_word <= pin.data;
						dma_wr_valid <= 1'b1;
					end
				end else if (pio_start) begin
					host_data_bus_oe <= 1'b0;
					pio_write_q <= wr_fall;
					pio_addr_q <= dec_addr;
					// Lowered, except in no-wait mode, well before the host samples it.
					ready_wait_out <= cfg.no_wait;
					if (rd_fall) begin
						pio_req <= '{write: 1'b0, addr: dec_addr,
							wdata: DATA_RST};
						pio_req_valid <= 1'b1;
						state_q <= S_PIO_WAIT;
					end else begin
						state_q <= cfg.no_wait ? S_PIO_HOLD : S_PIO_WAIT;
					end
				end else begin
					host_data_bus_oe <= dmack & host_data_bus_oe;
				end
			end
			S_PIO_WAIT: begin
				if (pio_done) begin
					if (pio_write_q) begin
						ready_wait_out <= 1'b1;
						state_q <= S_PIO_HOLD;
					end else begin
						host_data_bus_out <= pio_rd_data;
						host_data_bus_oe <= 1'b1;
						state_q <= S_PIO_DATA;
					end
				end
			end
			S_PIO_DATA: begin
				// Data has stood one cycle before ready returns.
				ready_wait_out <= 1'b1;
				state_q <= S_PIO_HOLD;
			end
			S_PIO_HOLD: begin
				if (~pio_write_q & rd_rise) begin
					host_data_bus_oe <= 1'b0;
					state_q <= S_IDLE;
				end else if (pio_write_q & wr_rise) begin
					pio_req <= '{write: 1'b1, addr: pio_addr_q,
						wdata: pin.data};
					pio_req_valid <= 1'b1;
					state_q <= S_IDLE;
				end
			end
			S_UD_RD: begin
				// Read strobe is HDMARDY#, write strobe STOP, and the
				// ready-wait pin is DSTROBE.
				if (dmack_end) begin
					host_data_bus_oe <= 1'b0;
					crc_word <= pin.data;
					crc_valid <= 1'b1;
					state_q <= S_IDLE;
				end else if (!tmr_zero) begin
					tmr_q <= tmr_dec;
				end else if (rd_burst_end) begin
					tmr_q <= T_SS_CYC;
					state_q <= S_UD_END;
				end else if (hdmardy) begin
					// Edges only while the host is ready, so a negated
					// ready stops them within two core cycles.
					if (phase_q == 1'b0) begin
						host_data_bus_out <= dma_rd_word;
						host_data_bus_oe <= 1'b1;
						dma_rd_take <= 1'b1;
						tmr_q <= half_cyc - 8'h01;
						phase_q <= 1'b1;
					end else begin
						ready_wait_out <= ~ready_wait_out;
						phase_q <= 1'b0;
					end
				end
			end
			S_UD_WR: begin
				// Read strobe is HSTROBE, ready-wait is DDMARDY#.
				if (dmack_end) begin
					crc_word <= pin.data;
					crc_valid <= 1'b1;
					ready_wait_out <= READY_RST;
					state_q <= S_IDLE;
				end else begin
					if (hstrobe_edge) begin
						dma_wr_word <= pin.data;
						dma_wr_valid <= 1'b1;
					end
					if (!tmr_zero) begin
						tmr_q <= tmr_dec;
						paused_q <= (tmr_q == 8'h01);
					end else if (~ready_wait_out & ~dma_wr_ready) begin
						ready_wait_out <= 1'b1;
						tmr_q <= rp_cyc;
					end else if (ready_wait_out & dma_wr_ready & paused_q) begin
						ready_wait_out <= 1'b0;
						paused_q <= 1'b0;
					end
					dma_request_out <= cfg.dma_active;
				end
			end
			S_UD_END: begin
				// Request drops after the strobe-to-stop time, or at once when DMACK# is released.
				if (dmack_end) begin
					host_data_bus_oe <= 1'b0;
					crc_word <= pin.data;
					crc_valid <= 1'b1;
					dma_request_out <= 1'b0;
					state_q <= S_IDLE;
				end else if (!tmr_zero) begin
					tmr_q <= tmr_dec;
				end else begin
					dma_request_out <= 1'b0;
					host_data_bus_oe <= 1'b0;
				end
			end
			default: begin
				state_q <= S_IDLE;
			end
			endcase
		end
	end

endmodule : ata_host_port

// ---- hw/ata_port_pkg.sv ----
// Shared constants, timing tables and carrier types of the host port.
package ata_port_pkg;

	// Core clock period; all time-to-cycle conversions use it.
	localparam int CLK_PERIOD_PS = 8000;

	// Ultra DMA modes covered by the tables below.
	localparam int UDMA_MODES = 6;
	localparam logic [2:0] UDMA_TOP_MODE = 3'h5;

	// Typical two-edge strobe period, ready-to-pause and strobe-to-stop times.
	localparam int T_2CYCTYP_NS [0:UDMA_MODES-1] = '{240, 160, 120, 90, 60, 40};
	localparam int T_RP_NS [0:UDMA_MODES-1] = '{160, 125, 100, 100, 100, 85};
	localparam int T_SS_NS = 50;

	// Reset values of the pin-facing outputs and of the internal timer.
	localparam logic READY_RST = 1'b1;
	localparam logic DMARQ_RST = 1'b0;
	localparam logic OE_RST = 1'b0;
	localparam logic [15:0] DATA_RST = 16'h0000;
	localparam logic [7:0] TMR_RST = 8'h00;

	// Address lines kept in the disk-compatible mode.
	localparam int DISK_ADDR_BITS = 3;

	// Pin bundle as it arrives from the connector, all active low strobes.
	typedef struct packed {
		logic rd_n;
		logic wr_n;
		logic dmack_n;
		logic ce_low_n;
		logic ce_high_n;
		logic [10:0] addr;
		logic [15:0] data;
	} host_pins_t;

	localparam int PINS_W = $bits(host_pins_t);

	// Transfer configuration set by the device controller.
	typedef struct packed {
		logic disk_mode;
		logic udma_en;
		logic dma_read;
		logic dma_active;
		logic no_wait;
		logic [2:0] mode;
	} xfer_cfg_t;

	// Register-cycle request handed to the device controller.
	typedef struct packed {
		logic write;
		logic [10:0] addr;
		logic [15:0] wdata;
	} pio_req_t;

	// Least time in ns to whole core cycles, never below one.
	function automatic logic [7:0] ns_to_cyc_up(input int ns);
		int c;
		c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
		if (c < 1) begin
			c = 1;
		end
		return c[7:0];
	endfunction : ns_to_cyc_up

	// Clamp to the fastest tabled mode, never beyond it.
	function automatic int mode_index(input logic [2:0] mode);
		return (mode > UDMA_TOP_MODE) ? int'(UDMA_TOP_MODE) : int'(mode);
	endfunction : mode_index

	function automatic logic [7:0] udma_half_cyc(input logic [2:0] mode);
		return ns_to_cyc_up(T_2CYCTYP_NS[mode_index(mode)] / 2);
	endfunction : udma_half_cyc

	function automatic logic [7:0] udma_rp_cyc(input logic [2:0] mode);
		return ns_to_cyc_up(T_RP_NS[mode_index(mode)]);
	endfunction : udma_rp_cyc

	localparam logic [7:0] T_SS_CYC = ns_to_cyc_up(T_SS_NS);

endpackage : ata_port_pkg

// ---- hw/pin_sync.sv ----
// Two-stage synchroniser for a bundle of asynchronous pins.
`timescale 1ns/1ps
module pin_sync #(
	parameter int W = 8,
	parameter logic [W-1:0] INIT = '1
) (
	input wire logic ref_clk, // Core clock.
	input wire logic rst, // Synchronous reset, active high.
	input wire logic [W-1:0] d, // Asynchronous pin levels.
	output logic [W-1:0] q // Synchronised levels.
);

	logic [W-1:0] meta_q;

	// The first stage feeds nothing but the second stage.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			meta_q <= INIT;
			q <= INIT;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end

endmodule : pin_sync

// ---- verification/ata_host_port_sva.sv ----
// Checker of the host port's pin timing relations.
`timescale 1ns/1ps
module ata_host_port_sva
	import ata_port_pkg::*;
(
	input wire logic ref_clk, // Core clock.
	input wire logic rst, // Synchronous reset.
	input wire logic host_read_strobe_n, // Read strobe pin.
	input wire logic host_data_bus_oe, // Data drive enable.
	input wire logic ready_wait_out, // Ready-wait pin.
	input wire logic dma_request_out, // DMA request.
	input wire xfer_cfg_t cfg, // Transfer configuration.
	input wire pio_req_t pio_req, // Register request.
	input wire logic pio_req_valid, // Request pulse.
	input wire logic pio_done, // Controller answer.
	input wire logic dma_wr_valid, // Received word pulse.
	input wire logic burst_active // Burst flag.
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	sequence s_dstrobe_edge;
		burst_active && cfg.dma_read && $changed(ready_wait_out);
	endsequence
	sequence s_host_paused;
		(burst_active && cfg.dma_read && host_read_strobe_n) [*8];
	endsequence
	property p_wait_rd;
		pio_req_valid && !pio_req.write && !cfg.no_wait |-> !ready_wait_out;
	endproperty
	a_wait_rd: assert property (p_wait_rd) else $error("no wait on read");
	property p_no_wait;
		cfg.no_wait && !cfg.dma_active |-> ready_wait_out;
	endproperty
	a_no_wait: assert property (p_no_wait) else $error("wait in no-wait");
	property p_release;
		!cfg.dma_active && $rose(ready_wait_out) |-> $past(pio_done) || $past(pio_done, 2);
	endproperty
	a_release: assert property (p_release) else $error("early release");
	property p_data_first;
		!cfg.dma_active && $rose(ready_wait_out) && host_data_bus_oe |-> $past(host_data_bus_oe);
	endproperty
	a_data_first: assert property (p_data_first) else $error("late data");
	property p_rq_idle;
		(!cfg.dma_active) [*2] |-> !dma_request_out;
	endproperty
	a_rq_idle: assert property (p_rq_idle) else $error("stray request");
	property p_udma_only;
		burst_active |-> cfg.udma_en && cfg.dma_active;
	endproperty
	a_udma_only: assert property (p_udma_only) else $error("stray burst");
	property p_half;
		s_dstrobe_edge ##1 burst_active |-> $stable(ready_wait_out);
	endproperty
	a_half: assert property (p_half) else $error("strobe too fast");
	property p_pause;
		s_host_paused |-> $stable(ready_wait_out);
	endproperty
	a_pause: assert property (p_pause) else $error("strobe in pause");
	property p_wr_word;
		burst_active && !cfg.dma_read && $changed(host_read_strobe_n) |-> ##[1:5] dma_wr_valid;
	endproperty
	a_wr_word: assert property (p_wr_word) else $error("word lost");
	property p_disk;
		pio_req_valid && cfg.disk_mode |-> pio_req.addr[10:3] == 8'h00;
	endproperty
	a_disk: assert property (p_disk) else $error("high address");
endmodule : ata_host_port_sva
bind ata_host_port ata_host_port_sva i_sva (.ref_clk, .rst, .host_read_strobe_n,
	.host_data_bus_oe, .ready_wait_out, .dma_request_out, .cfg, .pio_req,
	.pio_req_valid, .pio_done, .dma_wr_valid, .burst_active);

// ---- verification/ata_host_model.sv ----
// Behavioural host controller driving the card's connector pins.
`timescale 1ns/1ps
module ata_host_model (
	input wire logic ref_clk, // Core clock, paces the pins.
	input wire logic ready_wait_out, // Ready-wait or device strobe.
	input wire logic dma_request_out, // DMA request.
	input wire logic [15:0] bus, // Resolved data wires.
	output logic rd_n = 1'b1, // Read strobe pin.
	output logic wr_n = 1'b1, // Write strobe or stop pin.
	output logic ack_n = 1'b1, // Acknowledge pin.
	output logic ce_n = 1'b1, // Card enable pin.
	output logic [10:0] addr = 11'h000, // Address pins.
	output logic [15:0] dq = 16'h0000, // Data the host drives.
	output logic dq_oe = 1'b0, // High while the host drives data.
	output logic [15:0] got = 16'h0000, // Word captured by the host.
	output logic got_v = 1'b0 // Pulse with got.
);
	task automatic tick(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : tick
	task automatic grab();
		got = bus;
		got_v = 1'b1;
		tick(1);
		got_v = 1'b0;
	endtask : grab
	// Bounded so a dead device shows up as a mismatch, not a hang.
	task automatic wait_on(input logic sel, input logic lvl);
		for (int i = 0; i < 300; i++) begin
			if ((sel ? dma_request_out : ready_wait_out) === lvl) break;
			tick(1);
		end
	endtask : wait_on
	task automatic pio(input logic w, input logic [10:0] a, input logic [15:0] d);
		addr = a;
		ce_n = 1'b0;
		dq = d;
		dq_oe = w;
		tick(2);
		rd_n = w;
		wr_n = !w;
		tick(6);
		wait_on(1'b0, 1'b1);
		if (!w) grab();
		rd_n = 1'b1;
		wr_n = 1'b1;
		tick(2);
		dq_oe = 1'b0;
		ce_n = 1'b1;
		tick(5);
	endtask : pio
	task automatic udma_rd(input int stop_at, input logic [15:0] crc);
		logic last;
		wait_on(1'b1, 1'b1);
		ack_n = 1'b0;
		tick(4);
		last = ready_wait_out;
		for (int i = 0; i < 3000 && dma_request_out; i++) begin
			rd_n = (i >= 60 && i < 90);
			wr_n = (i < stop_at);
			if (ready_wait_out !== last) begin
				last = ready_wait_out;
				grab();
			end else begin
				tick(1);
			end
		end
		dq = crc;
		dq_oe = 1'b1;
		tick(2);
		ack_n = 1'b1;
		tick(3);
		dq_oe = 1'b0;
		rd_n = 1'b1;
		wr_n = 1'b1;
		tick(6);
	endtask : udma_rd
	// Strobe phases stretched past the minima, with one pause by DMACK.
	task automatic mdma(input logic w, input int n, input logic [15:0] base);
		wait_on(1'b1, 1'b1);
		ack_n = 1'b0;
		tick(2);
		for (int i = 0; i < n; i++) begin
			dq = base + i[15:0];
			dq_oe = w;
			tick(2);
			rd_n = w;
			wr_n = !w;
			tick(8);
			if (!w) grab();
			rd_n = 1'b1;
			wr_n = 1'b1;
			tick(8);
			if (i == 1) begin
				ack_n = 1'b1;
				tick(6);
				ack_n = 1'b0;
				tick(2);
			end
		end
		ack_n = 1'b1;
		dq_oe = 1'b0;
		tick(6);
	endtask : mdma
	// Half periods are sized for the slowest mode, so any mode is legal.
	task automatic udma_wr(input int n, input logic [15:0] base, input logic [15:0] crc);
		wait_on(1'b1, 1'b1);
		ack_n = 1'b0;
		tick(6);
		for (int i = 0; i < n; i++) begin
			dq = base + i[15:0];
			dq_oe = 1'b1;
			wait_on(1'b0, 1'b0);
			tick(3);
			rd_n = !rd_n;
			tick(12);
		end
		wr_n = 1'b0;
		tick(4);
		dq = crc;
		tick(2);
		ack_n = 1'b1;
		tick(3);
		dq_oe = 1'b0;
		wr_n = 1'b1;
		tick(6);
	endtask : udma_wr
endmodule : ata_host_model

// ---- verification/test_ata_host_port.sv ----
// Self-checking bench of the card's host port.
`timescale 1ns/1ps
module test_ata_host_port
	import ata_port_pkg::*;
;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic rd_n, wr_n, ack_n, ce_n, dq_oe, got_v, d_oe, rdy, rq, req_v, take;
	logic wr_v, crc_v, burst, pio_w;
	logic done = 1'b0;
	logic wr_rdy = 1'b1;
	logic [10:0] addr, a;
	logic [15:0] dq, got, d_out, wr_word, crc, d;
	logic [15:0] rd_data = 16'h0000;
	logic [15:0] rd_word = 16'h1234;
	xfer_cfg_t cfg = '0;
	pio_req_t req;
	logic [27:0] exp_q[$];
	int errors = 0;
	int num_checks = 0;
	int seed = 7887;
	wire logic [15:0] bus = d_oe ? d_out : (dq_oe ? dq : ~dq);
	always #4 ref_clk = ~ref_clk;
	ata_host_model i_host (.ref_clk, .ready_wait_out(rdy), .dma_request_out(rq),
		.bus, .rd_n, .wr_n, .ack_n, .ce_n, .addr, .dq, .dq_oe, .got, .got_v);
	ata_host_port i_dut (.ref_clk, .rst, .host_read_strobe_n(rd_n),
		.host_write_strobe_n(wr_n), .attribute_select_n(ack_n),
		.card_enable_low_n(ce_n), .card_enable_high_n(1'b1),
		.host_address_bus(addr), .host_data_bus_in(bus), .host_data_bus_out(d_out),
		.host_data_bus_oe(d_oe), .ready_wait_out(rdy), .dma_request_out(rq), .cfg,
		.pio_req(req), .pio_req_valid(req_v), .pio_rd_data(rd_data), .pio_done(done),
		.dma_rd_word(rd_word), .dma_rd_valid(1'b1), .dma_rd_take(take),
		.dma_wr_word(wr_word), .dma_wr_valid(wr_v), .dma_wr_ready(wr_rdy),
		.crc_word(crc), .crc_valid(crc_v), .burst_active(burst));
	task automatic chk(input logic [27:0] seen, input logic [27:0] want);
		num_checks++;
		if (seen !== want) begin
			errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, want);
		end
	endtask : chk
	function automatic logic [27:0] pop();
		return exp_q.size() ? exp_q.pop_front() : 28'hXXXXXXX;
	endfunction : pop
	always @(posedge ref_clk) begin
		if (req_v) chk({req.write, req.addr, req.write ? req.wdata : 16'h0000}, pop());
		if (got_v) chk({12'h000, got}, pop());
		if (wr_v) chk({12'h000, wr_word}, pop());
		if (crc_v) chk({12'h000, crc}, {12'h000, dq});
	end
	// The controller stalls now and then inside a burst.
	always @(negedge ref_clk) begin
		wr_rdy = !burst || ($unsigned($random(seed)) % 8 != 0);
	end
	// The controller answers a wait after a random delay.
	always @(negedge ref_clk) begin
		if (cfg.no_wait) begin
			done = 1'b1;
		end else if (!rst && !burst && !rdy && !done && !cfg.dma_active) begin
			repeat ($unsigned($random(seed)) % 6) @(negedge ref_clk);
			rd_data = $random(seed);
			done = 1'b1;
			if (!pio_w) exp_q.push_back({12'h000, rd_data});
		end else if (rdy) begin
			done = 1'b0;
		end
	end
	always @(negedge ref_clk) begin
		if (take) begin
			exp_q.push_back({12'h000, rd_word});
			rd_word = $random(seed);
		end
	end
	task automatic results();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : results
	initial begin
		#200000;
		errors++;
		results();
	end
	initial begin
		repeat (8) @(posedge ref_clk);
		@(negedge ref_clk);
		rst = 1'b0;
		repeat (4) @(negedge ref_clk);
		for (int k = 0; k < 8; k++) begin
			cfg.disk_mode = k[0];
			cfg.no_wait = (k == 7);
			a = $random(seed);
			d = $random(seed);
			pio_w = k[1] | cfg.no_wait;
			exp_q.push_back({pio_w, cfg.disk_mode ? {8'h00, a[2:0]} : a,
				pio_w ? d : 16'h0000});
			i_host.pio(pio_w, a, d);
		end
		cfg = '0;
		cfg.udma_en = 1'b1;
		cfg.dma_active = 1'b1;
		cfg.mode = 3'($unsigned($random(seed)) % 6);
		d = $random(seed);
		for (int k = 0; k < 6; k++) exp_q.push_back({12'h000, d + k[15:0]});
		i_host.udma_wr(6, d, 16'hC3A5);
		cfg.dma_active = 1'b0;
		repeat (4) @(negedge ref_clk);
		cfg.dma_read = 1'b1;
		cfg.dma_active = 1'b1;
		i_host.udma_rd(150, 16'h5A3C);
		cfg = '0;
		repeat (10) @(negedge ref_clk);
		cfg.dma_active = 1'b1;
		for (int k = 0; k < 2; k++) begin
			cfg.dma_read = k[0];
			d = $random(seed);
			if (!k[0]) for (int j = 0; j < 4; j++) exp_q.push_back({12'h000, d + j[15:0]});
			i_host.mdma(!k[0], 4, d);
		end
		cfg = '0;
		repeat (10) @(negedge ref_clk);
		results();
	end
endmodule : test_ata_host_port
